// ==== dv/rtcam_host.sv ====
// Purpose: host model issuing decoded byte register accesses
// Assumes: one-cycle strobes, changed at the falling edge
// Notes: idle address is unmapped and idle data inverted after a write (5ah after a read), so stale values never help
`timescale 1ns/100ps
`default_nettype none
module rtcam_host (
	input wire logic i_sys_clk,
	output var rtcam_pkg::rtcam_reg_req_t o_req
);
	initial o_req = '{8'hff, 1'h0, 1'h0, 8'h00};
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_sys_clk) o_req <= '{a, 1'h1, 1'h0, d};
		@(negedge i_sys_clk) o_req <= '{8'hff, 1'h0, 1'h0, ~d};
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge i_sys_clk) o_req <= '{a, 1'h0, 1'h1, 8'h00};
		@(negedge i_sys_clk) o_req <= '{8'hff, 1'h0, 1'h0, 8'h5a};
	endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Purpose: self-checking bench for the second alarm matcher
// Assumes: inputs change at the falling edge
// Notes: pulses are counted over a short window so a stuck or repeated event shows
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic i_sys_clk = 1'h0;
	logic i_reset_n = 1'h0;
	rtcam_pkg::rtcam_reg_req_t req;
	rtcam_pkg::rtcam_time_t tm = '0;
	logic [7:0] rdata;
	logic irq_n;
	int fails = 0;
	int compares = 0;
	int pulses;
	logic [63:0] tbl [9];
	always #5 i_sys_clk = ~i_sys_clk;
	rtcam_host host (.i_sys_clk(i_sys_clk), .o_req(req));
	rtcam_matcher dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_reg_req(req),
		.i_time(tm), .o_reg_rdata(rdata), .o_irq_out_or_ref_clock_in_n(irq_n));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %0t %h %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		if (fails == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// seconds held at 00 afterwards, so a repeated event would be counted too
	task automatic tick(input logic [63:0] t);
		@(negedge i_sys_clk) tm <= '{8'h59, t[39:32], t[31:24], t[23:16], t[15:8]};
		@(negedge i_sys_clk) tm.seconds <= 8'h00;
		pulses = 0;
		repeat (4) @(negedge i_sys_clk) pulses += (irq_n === 1'h0) ? 1 : 0;
		chk(8'(pulses), t[7:0]);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// entry: min reg, hour reg, day/date reg, minutes, hours, day, date, pulses
	initial begin
		tbl = '{64'h8080800000010101, 64'h2580802509010101, 64'h2580802609010100,
			64'h2517802517010101, 64'h2517802518010100, 64'h2517122517031201,
			64'h2517122517031300, 64'h2517432517031301, 64'h2517432517041200};
		repeat (2) @(negedge i_sys_clk);
		i_reset_n = 1'h1;
		foreach (tbl[j]) begin
			if (j < 4) begin
				host.rd(j == 3 ? 8'h20 : 8'(8'h13 + j));
				chk(rdata, 8'h00);
			end
		end
		host.wr(8'h04, 8'hff);
		host.rd(8'h04);
		chk(rdata, 8'h02);
		foreach (tbl[i]) begin
			// top down, so the minutes write sits one quiet cycle before its read back
			for (int j = 2; j >= 0; j--)
				host.wr(8'(8'h13 + j), tbl[i][63 - 8 * j -: 8]);
			for (int j = 0; j < 3; j++) begin
				host.rd(8'(8'h13 + j));
				chk(rdata, tbl[i][63 - 8 * j -: 8]);
			end
			tick(tbl[i]);
		end
		host.wr(8'h04, 8'h00);
		tick({tbl[7][63:8], 8'h00});
		end_of_test();
	end
endmodule
`default_nettype wire

// ==== verilog/rtcam_matcher.sv ====
// Purpose: second time-of-day alarm: registers, mask decode and match event
// Assumes: timekeeping values and register requests synchronous to i_sys_clk
// Notes: the serial engine in front presents decoded byte reads and writes
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - all three masks set alarms every minute, minute mask clear matches minutes, hour mask clear adds hours.
// - with all masks clear the alarm needs minute, hour and the chosen day or date to match.
// - bit 6 of the day/date register picks the date of month when 0 and the weekday when 1.
// - with the enable bit in register 04h set, a match drives the shared interrupt pin.
// - bit 7 of each alarm register masks its field out of the comparison.
// - the hours register holds 24-hour tens in 5:4 and units in 3:0, bit 6 stored as written but left out of the match.
// - the day/date register holds tens 5:4, units 3:0, select in 6, mask in 7, reset zero.
module rtcam_matcher (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire rtcam_pkg::rtcam_reg_req_t i_reg_req,
	input wire rtcam_pkg::rtcam_time_t i_time,
	output logic [7:0] o_reg_rdata,
	output logic o_irq_out_or_ref_clock_in_n
);

	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] alm_min_q, alm_min_d;
	logic [7:0] alm_hrs_q, alm_hrs_d;
	logic [7:0] alm_dd_q, alm_dd_d;
	logic alarm_two_irq_enable_q, alarm_two_irq_enable_d;
	logic [7:0] rdata_q, rdata_d;

	always_comb begin
		alm_min_d = alm_min_q;
		alm_hrs_d = alm_hrs_q;
		alm_dd_d = alm_dd_q;
		alarm_two_irq_enable_d = alarm_two_irq_enable_q;
		rdata_d = rdata_q;
		if (i_reg_req.wr) begin
			unique case (i_reg_req.addr)
				rtcam_pkg::OFS_SECOND_ALARM_MINUTES: alm_min_d = i_reg_req.wdata;
				// bit 6 is stored as written so software reads back what it wrote
				rtcam_pkg::OFS_SECOND_ALARM_HOURS: alm_hrs_d = i_reg_req.wdata;
				rtcam_pkg::OFS_ALM2_DAY_DATE: alm_dd_d = i_reg_req.wdata;
				rtcam_pkg::OFS_INT_EN: begin
					alarm_two_irq_enable_d = i_reg_req.wdata[rtcam_pkg::IRQ_EN_BIT];
				end
				default: begin
				end
			endcase
		end
		if (i_reg_req.rd) begin
			unique case (i_reg_req.addr)
				rtcam_pkg::OFS_SECOND_ALARM_MINUTES: rdata_d = alm_min_q;
				rtcam_pkg::OFS_SECOND_ALARM_HOURS: rdata_d = alm_hrs_q;
				rtcam_pkg::OFS_ALM2_DAY_DATE: rdata_d = alm_dd_q;
				rtcam_pkg::OFS_INT_EN: begin
					rdata_d = rtcam_pkg::RST_REG;
					rdata_d[rtcam_pkg::IRQ_EN_BIT] = alarm_two_irq_enable_q;
				end
				default: rdata_d = rtcam_pkg::RST_REG;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			alm_min_q <= rtcam_pkg::RST_REG;
			alm_hrs_q <= rtcam_pkg::RST_REG;
			alm_dd_q <= rtcam_pkg::RST_REG;
			alarm_two_irq_enable_q <= 1'b0;
			rdata_q <= rtcam_pkg::RST_REG;
		end else begin
			alm_min_q <= alm_min_d;
			alm_hrs_q <= alm_hrs_d;
			alm_dd_q <= alm_dd_d;
			alarm_two_irq_enable_q <= alarm_two_irq_enable_d;
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// match
	logic alarm_two_minute_mask, alarm_two_hour_mask, alarm_two_daydate_mask;
	logic day_or_date_select;
	logic min_ok, hr_ok, dd_ok, rollover, match;
	logic [7:0] sec_prev_q, sec_prev_d;
	logic irq_n_q, irq_n_d;

	assign alarm_two_minute_mask = alm_min_q[rtcam_pkg::MASK_BIT];
	assign alarm_two_hour_mask = alm_hrs_q[rtcam_pkg::MASK_BIT];
	assign alarm_two_daydate_mask = alm_dd_q[rtcam_pkg::MASK_BIT];
	assign day_or_date_select = alm_dd_q[rtcam_pkg::DAY_SEL_BIT];

	always_comb begin
		min_ok = alarm_two_minute_mask || (i_time.minutes[6:0] == alm_min_q[6:0]);
		hr_ok = alarm_two_hour_mask || (i_time.hours[5:0] == alm_hrs_q[5:0]);
		// select picks weekday or date of month for the low six bits
		if (day_or_date_select) begin
			dd_ok = (i_time.day[5:0] == alm_dd_q[5:0]);
		end else begin
			dd_ok = (i_time.date[5:0] == alm_dd_q[5:0]);
		end
		dd_ok = dd_ok || alarm_two_daydate_mask;
		// a single event per minute even though the time stands for a whole second
		rollover = (i_time.seconds == rtcam_pkg::SECONDS_ZERO)
			&& (sec_prev_q != rtcam_pkg::SECONDS_ZERO);
		match = rollover && min_ok && hr_ok && dd_ok;
		sec_prev_d = i_time.seconds;
		irq_n_d = !(match && alarm_two_irq_enable_q);
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sec_prev_q <= 8'h00;
			irq_n_q <= 1'b1;
		end else begin
			sec_prev_q <= sec_prev_d;
			irq_n_q <= irq_n_d;
		end
	end

	assign o_reg_rdata = rdata_q;
	assign o_irq_out_or_ref_clock_in_n = irq_n_q;

	////////////////////////////////////////////////////////////////////////////
	// checks
	property p_every_minute;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(alm_min_q[7] && alm_hrs_q[7] && alm_dd_q[7] && alarm_two_irq_enable_q
			&& i_time.seconds == 8'h00 && sec_prev_q != 8'h00)
		|=> !o_irq_out_or_ref_clock_in_n;
	endproperty
	a_every_minute: assert property (p_every_minute) else $error("no per-minute alarm");

	property p_full_match;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(!alm_min_q[7] && !alm_hrs_q[7] && !alm_dd_q[7]
			&& i_time.minutes[6:0] != alm_min_q[6:0])
		|=> o_irq_out_or_ref_clock_in_n;
	endproperty
	a_full_match: assert property (p_full_match) else $error("alarm on minute mismatch");

	property p_day_select;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(!alm_dd_q[7] && alm_dd_q[6] && i_time.day[5:0] != alm_dd_q[5:0])
		|=> o_irq_out_or_ref_clock_in_n;
	endproperty
	a_day_select: assert property (p_day_select) else $error("alarm with weekday mismatch");

	property p_enable_gate;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		!alarm_two_irq_enable_q |=> o_irq_out_or_ref_clock_in_n;
	endproperty
	a_enable_gate: assert property (p_enable_gate) else $error("irq while disabled");

	property p_mask_hour;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(alm_hrs_q[7] && !alm_min_q[7] && alm_dd_q[7] && rollover && alarm_two_irq_enable_q
			&& i_time.minutes[6:0] == alm_min_q[6:0])
		|=> !o_irq_out_or_ref_clock_in_n;
	endproperty
	a_mask_hour: assert property (p_mask_hour) else $error("masked field blocked alarm");

	property p_min_write;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		// write, one quiet cycle, then read back the same register
		(i_reg_req.wr && i_reg_req.addr == rtcam_pkg::OFS_SECOND_ALARM_MINUTES && !i_reg_req.rd)
		##1 !i_reg_req.wr
		##1 (i_reg_req.rd && i_reg_req.addr == rtcam_pkg::OFS_SECOND_ALARM_MINUTES && !i_reg_req.wr)
		|=> o_reg_rdata == $past(i_reg_req.wdata, 3);
	endproperty
	a_min_write: assert property (p_min_write) else $error("minutes readback wrong");

	property p_dd_write;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(i_reg_req.wr && i_reg_req.addr == 8'h15) |=> alm_dd_q == $past(i_reg_req.wdata);
	endproperty
	a_dd_write: assert property (p_dd_write) else $error("day/date not stored");

	property p_single_event;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		!o_irq_out_or_ref_clock_in_n |=> o_irq_out_or_ref_clock_in_n [*2];
	endproperty
	a_single_event: assert property (p_single_event) else $error("alarm not single");

	property p_min_store;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(i_reg_req.wr && i_reg_req.addr == rtcam_pkg::OFS_SECOND_ALARM_MINUTES)
		|=> alm_min_q == $past(i_reg_req.wdata);
	endproperty
	a_min_store: assert property (p_min_store) else $error("minutes not stored");

	property p_hrs_store;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(i_reg_req.wr && i_reg_req.addr == rtcam_pkg::OFS_SECOND_ALARM_HOURS)
		|=> alm_hrs_q == $past(i_reg_req.wdata);
	endproperty
	a_hrs_store: assert property (p_hrs_store) else $error("hours not stored");

	property p_hour_match;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(!alm_min_q[7] && !alm_hrs_q[7] && alm_dd_q[7] && rollover && alarm_two_irq_enable_q
			&& i_time.minutes[6:0] == alm_min_q[6:0] && i_time.hours[5:0] == alm_hrs_q[5:0])
		|=> !o_irq_out_or_ref_clock_in_n;
	endproperty
	a_hour_match: assert property (p_hour_match) else $error("hour and minute match missed");

	property p_date_select;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(!alm_dd_q[7] && !alm_dd_q[6] && i_time.date[5:0] != alm_dd_q[5:0])
		|=> o_irq_out_or_ref_clock_in_n;
	endproperty
	a_date_select: assert property (p_date_select) else $error("alarm with date mismatch");

	property p_full_alarm;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(!alm_min_q[7] && !alm_hrs_q[7] && !alm_dd_q[7] && rollover && alarm_two_irq_enable_q
			&& i_time.minutes[6:0] == alm_min_q[6:0] && i_time.hours[5:0] == alm_hrs_q[5:0]
			&& (alm_dd_q[6] ? i_time.day[5:0] : i_time.date[5:0]) == alm_dd_q[5:0])
		|=> !o_irq_out_or_ref_clock_in_n;
	endproperty
	a_full_alarm: assert property (p_full_alarm) else $error("full match missed");

	property p_needs_rollover;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		!(i_time.seconds == rtcam_pkg::SECONDS_ZERO && sec_prev_q != rtcam_pkg::SECONDS_ZERO)
		|=> o_irq_out_or_ref_clock_in_n;
	endproperty
	a_needs_rollover: assert property (p_needs_rollover) else $error("alarm off rollover");

endmodule
`default_nettype wire

// ==== verilog/rtcam_pkg.sv ====
// Purpose: shared constants and types for the second alarm matcher
// Assumes: byte-wide register map, bcd timekeeping values
// Notes: offsets are register addresses on the serial bus register map
`default_nettype none
package rtcam_pkg;
	localparam logic [7:0] OFS_INT_EN = 8'h04;
	localparam logic [7:0] OFS_SECOND_ALARM_MINUTES = 8'h13;
	localparam logic [7:0] OFS_SECOND_ALARM_HOURS = 8'h14;
	localparam logic [7:0] OFS_ALM2_DAY_DATE = 8'h15;
	localparam logic [7:0] RST_REG = 8'h00;
	localparam int IRQ_EN_BIT = 1;
	localparam int MASK_BIT = 7;
	localparam int DAY_SEL_BIT = 6;
	localparam logic [7:0] SECONDS_ZERO = 8'h00;

	typedef struct packed {
		logic [7:0] seconds;
		logic [7:0] minutes;
		logic [7:0] hours;
		logic [7:0] day;
		logic [7:0] date;
	} rtcam_time_t;

	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} rtcam_reg_req_t;
endpackage
`default_nettype wire
